// file: logic/prg_port.sv
module prg_port #(
    parameter int BEAT_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic pclk_i,
    input wire logic host_mode_i,
    input wire logic request_in_one_or_own_grant_n_i,
    input wire logic request_in_two_n_i,
    input wire logic request_in_three_n_i,
    output logic grant_out_one_or_own_request_n_o,
    output logic grant_out_two_n_o,
    output logic grant_out_three_n_o,
    input wire logic [prg_pkg::ADDR_DATA_W-1:0] ad_i,
    output logic [prg_pkg::ADDR_DATA_W-1:0] ad_o,
    output logic ad_oe_o,
    output logic phase_addr_o,
    output logic phase_data_o,
    input wire prg_pkg::prg_cmd_s cmd_i,
    input wire logic cmd_tgl_i,
    input wire logic [prg_pkg::ADDR_DATA_W-1:0] wdata_i,
    output logic [prg_pkg::ADDR_DATA_W-1:0] rdata_o,
    output logic rdata_tgl_o,
    output logic done_tgl_o
);
    import prg_pkg::*;

    // ------------------------------------------------------------
    // system-side synchronisers
    // ------------------------------------------------------------
    // host_mode and command toggle come from other domains; the link side
    // runs on pclk only, clk_i is kept for the user handshake result
    logic mode_s1_ff, mode_s2_ff;
    logic cmd_s1_ff, cmd_s2_ff, cmd_seen_ff;
    logic done_ff;
    logic done_s1_ff, done_s2_ff, done_out_ff;
    logic [ADDR_DATA_W-1:0] rdata_ff;

    // mode strap and command toggle cross into the bus clock
    always_ff @(posedge pclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_s1_ff <= 1'h0;
            mode_s2_ff <= 1'h0;
            cmd_s1_ff <= 1'h0;
            cmd_s2_ff <= 1'h0;
        end else begin
            mode_s1_ff <= host_mode_i;
            mode_s2_ff <= mode_s1_ff;
            cmd_s1_ff <= cmd_tgl_i;
            cmd_s2_ff <= cmd_s1_ff;
        end
    end

    // completion toggle crosses back into the system clock
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_s1_ff <= 1'h0;
            done_s2_ff <= 1'h0;
            done_out_ff <= 1'h0;
        end else begin
            done_s1_ff <= done_ff;
            done_s2_ff <= done_s1_ff;
            done_out_ff <= done_s2_ff;
        end
    end
    assign done_tgl_o = done_out_ff;

    // ------------------------------------------------------------
    // pin sampling on the bus clock
    // ------------------------------------------------------------
    // pins are registered on the rising pclk edge before use; nothing here
    // depends on the clock rate, so any bus clock in range works
    logic [2:0] req_s1_ff, req_s2_ff;
    always_ff @(posedge pclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_s1_ff <= 3'h7;
            req_s2_ff <= 3'h7;
        end else begin
            req_s1_ff <= {request_in_three_n_i, request_in_two_n_i,
                          request_in_one_or_own_grant_n_i};
            req_s2_ff <= req_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // host-mode round-robin arbiter
    // ------------------------------------------------------------
    logic [2:0] grant_n_ff, nxt_grant_n;
    logic [1:0] last_ff, nxt_last;
    logic [2:0] req_act;
    assign req_act = ~req_s2_ff;

    // rotate search start after the last winner; hold while owner still requests
    always_comb begin
        logic [1:0] idx;
        nxt_grant_n = GRANT_RST;
        nxt_last = last_ff;
        idx = 2'h0;
        if (grant_n_ff != GRANT_RST && (req_act & ~grant_n_ff) != 3'h0) begin
            nxt_grant_n = grant_n_ff;
        end else begin
            for (int k = 1; k <= NUM_REQ; k++) begin
                idx = 2'((32'(last_ff) + k) % NUM_REQ);
                if (req_act[idx] && nxt_grant_n == GRANT_RST) begin
                    nxt_grant_n = ~(3'h1 << idx);
                    nxt_last = idx;
                end
            end
        end
    end

    always_ff @(posedge pclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            grant_n_ff <= GRANT_RST;
            last_ff <= LAST_RST;
        end else if (mode_s2_ff) begin
            grant_n_ff <= nxt_grant_n;
            last_ff <= nxt_last;
        end else begin
            grant_n_ff <= GRANT_RST;
            last_ff <= LAST_RST;
        end
    end

    // ------------------------------------------------------------
    // guest-mode master sequencer
    // ------------------------------------------------------------
    prg_state_e state_ff;
    logic own_req_n_ff;
    logic [BEAT_W-1:0] beats_ff;
    logic [ADDR_DATA_W-1:0] ad_ff;
    logic ad_oe_ff, pa_ff, pd_ff;
    logic rd_tgl_ff;
    logic wr_ff;
    logic own_grant;
    assign own_grant = ~req_s2_ff[0];

    // one address phase, optional turnaround, then beats data phases
    always_ff @(posedge pclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= ST_IDLE;
            own_req_n_ff <= 1'h1;
            beats_ff <= '0;
            ad_ff <= '0;
            ad_oe_ff <= 1'h0;
            pa_ff <= 1'h0;
            pd_ff <= 1'h0;
            wr_ff <= 1'h0;
            cmd_seen_ff <= 1'h0;
            done_ff <= 1'h0;
            rdata_ff <= '0;
            rd_tgl_ff <= 1'h0;
        end else begin
            pa_ff <= 1'h0;
            case (state_ff)
                ST_IDLE: begin
                    pd_ff <= 1'h0;
                    ad_oe_ff <= 1'h0;
                    if (!mode_s2_ff && cmd_s2_ff != cmd_seen_ff) begin
                        cmd_seen_ff <= cmd_s2_ff;
                        wr_ff <= cmd_i.write;
                        // a zero count still moves one word
                        beats_ff <= BEAT_W'((cmd_i.beats == 8'h00) ? 8'h01 : cmd_i.beats);
                        ad_ff <= cmd_i.addr;
                        own_req_n_ff <= 1'h0;
                        state_ff <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (own_grant) begin
                        ad_oe_ff <= 1'h1;
                        pa_ff <= 1'h1;
                        state_ff <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    own_req_n_ff <= 1'h1;
                    if (wr_ff) begin
                        ad_ff <= wdata_i;
                        pd_ff <= 1'h1;
                        state_ff <= ST_DATA;
                    end else begin
                        ad_oe_ff <= 1'h0;
                        state_ff <= ST_TURN;
                    end
                end
                ST_TURN: begin
                    // nobody drives the lines this cycle
                    pd_ff <= 1'h1;
                    state_ff <= ST_DATA;
                end
                ST_DATA: begin
                    if (!wr_ff) begin
                        rdata_ff <= ad_i;
                        rd_tgl_ff <= ~rd_tgl_ff;
                    end else begin
                        ad_ff <= wdata_i;
                    end
                    beats_ff <= beats_ff - BEAT_W'(1);
                    if (beats_ff == BEAT_W'(1)) begin
                        pd_ff <= 1'h0;
                        ad_oe_ff <= 1'h0;
                        state_ff <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    done_ff <= ~done_ff;
                    state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // pairs two and three stay released in guest mode
    logic [2:0] gnt_pin_ff;
    always_ff @(posedge pclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gnt_pin_ff <= GRANT_RST;
        end else if (mode_s2_ff) begin
            gnt_pin_ff <= nxt_grant_n;
        end else begin
            gnt_pin_ff <= {2'h3, own_req_n_ff};
        end
    end
    assign grant_out_one_or_own_request_n_o = gnt_pin_ff[0];
    assign grant_out_two_n_o = gnt_pin_ff[1];
    assign grant_out_three_n_o = gnt_pin_ff[2];
    assign ad_o = ad_ff;
    assign ad_oe_o = ad_oe_ff;
    assign phase_addr_o = pa_ff;
    assign phase_data_o = pd_ff;
    assign rdata_o = rdata_ff;
    assign rdata_tgl_o = rd_tgl_ff;
endmodule : prg_port

// file: logic/prg_pkg.sv
package prg_pkg;
    // bus width of the multiplexed address/data lines
    localparam int ADDR_DATA_W = 32;
    // supported bus clock range, in MHz
    localparam int PCLK_MIN_MHZ = 20;
    localparam int PCLK_MAX_MHZ = 33;
    // number of external requesters in host bridge mode
    localparam int NUM_REQ = 3;
    // reset values
    localparam logic [2:0] GRANT_RST = 3'h7;
    localparam logic [1:0] LAST_RST = 2'h2;

    // transfer request from the internal side
    typedef struct packed {
        logic write;
        logic [ADDR_DATA_W-1:0] addr;
        logic [7:0] beats;
    } prg_cmd_s;

    // master phase sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REQ,
        ST_ADDR,
        ST_TURN,
        ST_DATA,
        ST_DONE
    } prg_state_e;
endpackage : prg_pkg

// file: bench/prg_port_chk.sv
// ------
// checks
// ------
module prg_port_chk (
    input wire logic pclk_i,
    input wire logic rst_b_i,
    input wire logic host_mode_i,
    input wire logic request_in_one_or_own_grant_n_i,
    input wire logic request_in_two_n_i,
    input wire logic grant_out_one_or_own_request_n_o,
    input wire logic grant_out_two_n_o,
    input wire logic grant_out_three_n_o,
    input wire logic ad_oe_o,
    input wire logic phase_addr_o,
    input wire logic phase_data_o,
    input wire prg_pkg::prg_cmd_s cmd_i
);
    timeunit 1ns;
    timeprecision 100ps;
    import prg_pkg::*;
    logic [2:0] g_n;
    // grant pins gathered, pin one on top
    assign g_n = {grant_out_one_or_own_request_n_o, grant_out_two_n_o, grant_out_three_n_o};
    default clocking cb @(posedge pclk_i);
    endclocking
    default disable iff (!rst_b_i);
    // one-cycle address phase; read turnaround leaves the lines undriven
    sequence s_addr;
        phase_addr_o && ad_oe_o ##1 !phase_addr_o;
    endsequence
    sequence s_turn;
        !ad_oe_o && !phase_data_o ##1 phase_data_o;
    endsequence
    property p_one;
        host_mode_i |-> $countones(g_n) >= 2;
    endproperty
    a_one: assert property (p_one) else $error("two grants low");
    property p_resv;
        !host_mode_i |-> g_n[1:0] == 2'h3;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved grant used");
    // pin sampled, two sync flops, arbiter, pin flop: request seen three edges back
    property p_cause;
        $fell(grant_out_two_n_o) |-> $past(!request_in_two_n_i, 3);
    endproperty
    a_cause: assert property (p_cause) else $error("grant without request");
    property p_addr;
        phase_addr_o |-> s_addr;
    endproperty
    a_addr: assert property (p_addr) else $error("bad address phase");
    property p_turn;
        phase_addr_o && !cmd_i.write |=> s_turn;
    endproperty
    a_turn: assert property (p_turn) else $error("no turnaround");
    property p_wr;
        phase_addr_o && cmd_i.write |=> phase_data_o && ad_oe_o;
    endproperty
    a_wr: assert property (p_wr) else $error("write data not driven");
    property p_rd;
        phase_data_o && !cmd_i.write |-> !ad_oe_o;
    endproperty
    a_rd: assert property (p_rd) else $error("device drives read data");
    // grant pin passes two sync flops before the sequencer acts on it
    property p_start;
        $rose(phase_addr_o) |-> $past(!request_in_one_or_own_grant_n_i, 3)
            && $past(!grant_out_one_or_own_request_n_o);
    endproperty
    a_start: assert property (p_start) else $error("master without grant");
endmodule : prg_port_chk

bind prg_port prg_port_chk i_prg_port_chk (.pclk_i, .rst_b_i, .host_mode_i,
    .request_in_one_or_own_grant_n_i, .request_in_two_n_i, .grant_out_one_or_own_request_n_o,
    .grant_out_two_n_o, .grant_out_three_n_o, .ad_oe_o, .phase_addr_o, .phase_data_o, .cmd_i);

// file: bench/prg_partner.sv
// ------------------------------
// far side: arbiter, read target
// ------------------------------
module prg_partner (
    input wire logic pclk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] dly_i,
    input wire logic req_n_i,
    input wire logic ad_oe_i,
    input wire logic phase_data_i,
    output logic gnt_n_o,
    output logic [31:0] ad_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_ff;
    logic [3:0] hold_ff;
    logic [7:0] beat_ff;
    logic [31:0] last_ff;
    // grant after dly_i cycles of request, then held 8 cycles
    always_ff @(posedge pclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_ff <= 4'h0;
            hold_ff <= 4'h0;
        end else if (hold_ff != 4'h0) begin
            hold_ff <= hold_ff - 4'h1;
        end else if (!req_n_i && wait_ff >= dly_i) begin
            hold_ff <= 4'h8;
            wait_ff <= 4'h0;
        end else begin
            wait_ff <= req_n_i ? 4'h0 : wait_ff + 4'h1;
        end
    end
    assign gnt_n_o = (hold_ff == 4'h0);
    // released lines flip every cycle so stale data never matches
    assign ad_o = (phase_data_i && !ad_oe_i) ? 32'hA500_0000 + 32'(beat_ff) : ~last_ff;
    // beat count and last level
    always_ff @(posedge pclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            beat_ff <= 8'h0;
            last_ff <= 32'h0;
        end else begin
            beat_ff <= phase_data_i ? beat_ff + 8'h1 : 8'h0;
            last_ff <= ad_o;
        end
    end
endmodule : prg_partner

// file: bench/prg_port_tb.sv
module prg_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import prg_pkg::*;
    typedef struct packed {
        logic w;
        logic [7:0] beats;
        logic [3:0] dly;
        logic [8:0] exp_n;
    } prg_row_s;
    // beats of 0 still move one word; 255 is the longest burst
    localparam prg_row_s ROWS [6] = '{'{1'h1, 8'h01, 4'h0, 9'h001}, '{1'h0, 8'h01, 4'h3, 9'h001},
        '{1'h1, 8'h04, 4'h5, 9'h004}, '{1'h0, 8'h00, 4'h0, 9'h001},
        '{1'h1, 8'hFF, 4'h2, 9'h0FF}, '{1'h0, 8'hFF, 4'h4, 9'h0FF}};
    logic clk = 1'h0, pclk = 1'h0, rst_b = 1'h0, hmode = 1'h0, tgl = 1'h0, pg_n;
    logic [2:0] req_n = 3'h7, prev;
    // three output ports drive separate bits, so this is a net
    wire logic [2:0] g_n;
    logic [3:0] dly = 4'h0;
    logic [31:0] wdata = 32'h0, ad_o, ad_in, rdata, got[$];
    prg_cmd_s cmd = '0;
    logic ad_oe, ph_a, ph_d, rtgl, done, rt_seen = 1'h0, dn_seen = 1'h0;
    int failures = 0, num_checks = 0, nbeat = 0, n;
    // unrelated clocks
    initial forever #5 clk = ~clk;
    initial begin
        #3;
        forever #32 pclk = ~pclk;
    end
    prg_port i_prg_port (.clk_i(clk), .rst_b_i(rst_b), .pclk_i(pclk), .host_mode_i(hmode),
        .request_in_one_or_own_grant_n_i(hmode ? req_n[2] : pg_n),
        .request_in_two_n_i(req_n[1]), .request_in_three_n_i(req_n[0]),
        .grant_out_one_or_own_request_n_o(g_n[2]), .grant_out_two_n_o(g_n[1]),
        .grant_out_three_n_o(g_n[0]), .ad_i(ad_in), .ad_o(ad_o), .ad_oe_o(ad_oe),
        .phase_addr_o(ph_a), .phase_data_o(ph_d), .cmd_i(cmd), .cmd_tgl_i(tgl),
        .wdata_i(wdata), .rdata_o(rdata), .rdata_tgl_o(rtgl), .done_tgl_o(done));
    prg_partner i_prg_partner (.pclk_i(pclk), .rst_b_i(rst_b), .dly_i(dly), .req_n_i(g_n[2]),
        .ad_oe_i(ad_oe), .phase_data_i(ph_d), .gnt_n_o(pg_n), .ad_o(ad_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    // data phases as the bus clock sees them
    always @(posedge pclk) begin
        if (ph_d) nbeat++;
        if (ph_a) chk(ad_o, 32'h0000_1040);
        if (ph_a) chk(32'(ad_oe), 32'h1);
        if (ph_d && ad_oe) chk(ad_o, wdata);
        if (rtgl !== rt_seen) got.push_back(rdata);
        rt_seen = rtgl;
    end
    // one transfer; reserved pairs held low to tempt the arbiter
    task automatic xfer(input prg_row_s r);
        int k;
        got.delete();
        nbeat = 0;
        @(posedge pclk);
        cmd <= '{r.w, 32'h0000_1040, r.beats};
        wdata <= {24'hC0DE00, r.beats};
        dly <= r.dly;
        req_n[1:0] <= 2'h0;
        @(posedge pclk);
        tgl <= ~tgl;
        k = 0;
        while (done === dn_seen && k < 3000) begin
            @(posedge clk);
            k++;
        end
        dn_seen = done;
        chk(32'(k < 3000), 32'h1);
        chk(32'(nbeat), 32'(r.exp_n));
        if (!r.w) chk(32'(got.size()), 32'(r.exp_n));
        if (!r.w) for (k = 0; k < r.exp_n; k++) chk(got[k], 32'hA500_0000 + k);
    endtask : xfer
    // guest rows, then host arbitration after a second reset
    initial begin
        repeat (4) @(posedge pclk);
        rst_b <= 1'h1;
        repeat (3) @(posedge pclk);
        foreach (ROWS[i]) xfer(ROWS[i]);
        rst_b <= 1'h0;
        hmode <= 1'h1;
        req_n <= 3'h7;
        repeat (3) @(posedge pclk);
        rst_b <= 1'h1;
        repeat (3) @(posedge pclk);
        // after reset nobody owns the bus and the lines are released
        chk(32'(g_n), 32'h7);
        chk(32'(ad_oe), 32'h0);
        req_n <= 3'h0;
        prev = 3'h7;
        for (int i = 0; i < 3; i++) begin
            n = 0;
            while ((g_n === 3'h7 || g_n === prev) && n < 20) begin
                @(posedge pclk);
                n++;
            end
            chk(32'(g_n), 32'(3'(~(3'h4 >> i))));
            prev = g_n;
            req_n <= req_n | ~g_n;
        end
        print_verdict();
    end
    // watchdog
    initial begin
        #400_000;
        failures++;
        print_verdict();
    end
endmodule : prg_port_tb
